/* File: verilog/rbs_pkg.sv */
// Constants shared by the branch / bit-set execute block.
// Assumes one 250 MHz clock; each clock is one phase of a four-phase instruction cycle.
// Overview of operation
// - Word with top five bits 11010 is the relative branch; low eleven bits are offset.
// - Branch offset is signed -1024..1023, doubled, added to already advanced PC.
// - Branch target equals the branch's own address plus two plus twice offset.
// - Neither branch nor bit set changes any arithmetic status flag.
// - Top four bits 1000 is bit set: bit select, bank mode, eight-bit file field.
// - Bit set forces the selected bit to one, other bits of the register unchanged.
// - Bank mode zero uses the shared bank; one uses bank select plus file field.
// - Bank mode zero with extended set enabled and file at most 95 uses indexed offset.
// - Prefix 1011 skips the next instruction when the tested bit reads zero.
// - Prefix 1010 skips the next instruction when the tested bit reads one.
// - A skip discards the fetched next instruction and runs a no-op, two cycles total.
package rbs_pkg;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam logic [4:0] OPC_BRANCH = 5'h1A;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam logic [3:0] OPC_TEST_CLR = 4'hB;
    localparam logic [3:0] OPC_TEST_SET = 4'hA;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam int OFFS_POS = 0;
    localparam int OFFS_W = 11;
    localparam int FILE_POS = 0;
    localparam int AMODE_POS = 8;
    localparam int BSEL_POS = 9;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rbs_phase_t;
endpackage : rbs_pkg

/* File: verilog/rbs_bitop_if.sv */
// Carrier between the execute sequencer and the bit operator.
// Assumes purely combinational use inside one clock domain.
interface rbs_bitop_if;
    logic [7:0] din;
    logic [2:0] sel;
    logic [7:0] dout;
    logic bit_val;
    modport calc (input din, input sel, output dout, output bit_val);
    modport user (output din, output sel, input dout, input bit_val);
endinterface : rbs_bitop_if

/* File: verilog/rbs_bitop.sv */
// Bit operator: sets one bit of a byte and reports its old value.
// Assumes the caller holds operand stable while reading results.
module rbs_bitop (
    rbs_bitop_if.calc b
);
    import rbs_pkg::*;
    logic [7:0] mask;
    always_comb begin
        mask = 8'h01 << b.sel;
        b.dout = b.din | mask;
        b.bit_val = |(b.din & mask);
    end
endmodule : rbs_bitop

/* File: verilog/rbs_exec.sv */
// Execute sequencer for the relative branch, bit set and the two bit-test-skip words.
// Assumes instr_i holds the word at fetch_addr_o and dmem_rdata_i answers dmem_addr_o in the same clock.
module rbs_exec (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0] dmem_rdata_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic ext_en_i,
    input wire logic [rbs_pkg::DADDR_W-1:0] idx_base_i,
    output logic [rbs_pkg::PC_W-1:0] fetch_addr_o,
    output logic [rbs_pkg::DADDR_W-1:0] dmem_addr_o,
    output logic dmem_rd_o,
    output logic dmem_we_o,
    output logic [7:0] dmem_wdata_o,
    output logic flags_we_o
);
    import rbs_pkg::*;

    rbs_phase_t ph_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] ir_addr_q;
    logic [15:0] ir_q;
    logic ir_valid_q;
    logic [DADDR_W-1:0] addr_q;
    logic rd_q;
    logic we_q;
    logic [7:0] wdata_q;
    logic [7:0] data_q;

    logic is_branch, is_bit_set, is_test_clr, is_test_set, is_mem;
    logic [7:0] ffield;
    logic amode;
    logic [PC_W-1:0] offs2;
    logic [DADDR_W-1:0] ea;
    logic skip_take;

    rbs_bitop_if bop ();
    rbs_bitop u_bitop (.b(bop));

    always_comb begin
        ffield = ir_q[FILE_POS +: 8];
        amode = ir_q[AMODE_POS];
        is_branch = ir_valid_q && (ir_q[15:11] == OPC_BRANCH);
        is_bit_set = ir_valid_q && (ir_q[15:12] == OPC_BIT_SET);
        is_test_clr = ir_valid_q && (ir_q[15:12] == OPC_TEST_CLR);
        is_test_set = ir_valid_q && (ir_q[15:12] == OPC_TEST_SET);
        is_mem = is_bit_set || is_test_clr || is_test_set;
        // Sign-extended offset times two
        offs2 = {{(PC_W-OFFS_W-1){ir_q[OFFS_POS+OFFS_W-1]}}, ir_q[OFFS_POS +: OFFS_W], 1'b0};
    end

    // Operand address: banked, indexed literal offset, or shared bank
    always_comb begin
        if (amode) begin
            ea = {bank_select_register_i, ffield};
        end else if (ext_en_i && (ffield <= INDEX_MAX)) begin
            ea = idx_base_i + {4'h0, ffield};
        end else if (ffield < ACCESS_SPLIT) begin
            ea = {ACCESS_LO_BANK, ffield};
        end else begin
            ea = {ACCESS_HI_BANK, ffield};
        end
    end

    always_comb begin
        bop.din = data_q;
        bop.sel = ir_q[BSEL_POS +: 3];
        skip_take = (is_test_clr && !bop.bit_val) || (is_test_set && bop.bit_val);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= PH_Q1;
        end else begin
            unique case (ph_q)
                PH_Q1: ph_q <= PH_Q2;
                PH_Q2: ph_q <= PH_Q3;
                PH_Q3: ph_q <= PH_Q4;
                PH_Q4: ph_q <= PH_Q1;
            endcase
        end
    end

    // Fetch at end of each cycle; branch or skip discards the fetched word
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_q <= PC_RESET;
            ir_q <= INSTR_RESET;
            ir_addr_q <= PC_RESET;
            ir_valid_q <= 1'b0;
        end else if (ph_q == PH_Q4) begin
            ir_q <= instr_i;
            ir_addr_q <= pc_q;
            if (is_branch) begin
                pc_q <= pc_q + offs2;
                ir_valid_q <= 1'b0;
            end else begin
                pc_q <= pc_q + PC_STEP;
                ir_valid_q <= !skip_take;
            end
        end
    end

    // Read in phase two, modify in three, write back in four
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= '0;
            rd_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= 8'h00;
            data_q <= 8'h00;
        end else begin
            unique case (ph_q)
                PH_Q1: begin
                    rd_q <= is_mem;
                    addr_q <= ea;
                end
                PH_Q2: begin
                    rd_q <= 1'b0;
                    data_q <= dmem_rdata_i;
                end
                PH_Q3: begin
                    we_q <= is_bit_set;
                    wdata_q <= bop.dout;
                end
                PH_Q4: we_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_we_o <= 1'b0;
        end else begin
            flags_we_o <= 1'b0;
        end
    end

    always_comb begin
        fetch_addr_o = pc_q;
        dmem_addr_o = addr_q;
        dmem_rd_o = rd_q;
        dmem_we_o = we_q;
        dmem_wdata_o = wdata_q;
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Branch and fetch
    a_branch_decode: assert property ((ph_q == PH_Q4 && ir_valid_q && ir_q[15:11] == 5'h1B)
        |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("word with bit eleven set taken as branch");
    a_branch_offset: assert property ((ph_q == PH_Q4 && is_branch) |=> pc_q == $past(pc_q) + $past(offs2))
        else $error("branch offset not added to advanced pc");
    a_branch_target: assert property ((ph_q == PH_Q4 && is_branch)
        |=> pc_q == $past(ir_addr_q) + PC_STEP + $past(offs2))
        else $error("branch target wrong");
    a_branch_flush: assert property ((ph_q == PH_Q4 && is_branch) |=> !ir_valid_q [*4])
        else $error("branch not followed by no-op cycle");
    a_branch_refill: assert property ((ph_q == PH_Q4 && is_branch) |=> ##4 ir_valid_q)
        else $error("target word not executed after no-op cycle");
    a_branch_no_access: assert property ((ph_q == PH_Q4 && is_branch) |=> (!dmem_rd_o && !dmem_we_o) [*4])
        else $error("memory touched in branch no-op cycle");
    a_pc_step: assert property ((ph_q == PH_Q4 && !is_branch) |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("pc did not step by one word");
    a_no_flags: assert property (!flags_we_o)
        else $error("status flags written");
    a_phase_order: assert property (ph_q == PH_Q4 |=> ph_q == PH_Q1)
        else $error("phase counter out of order");

    // Data access
    a_bitset_seq: assert property ((ph_q == PH_Q1 && is_bit_set)
        |=> dmem_rd_o ##1 !dmem_rd_o ##1 dmem_we_o ##1 !dmem_we_o)
        else $error("bit set phases wrong");
    a_bitset_value: assert property (dmem_we_o
        |-> dmem_wdata_o == (data_q | (8'h01 << ir_q[BSEL_POS +: 3])))
        else $error("bit set value wrong");
    a_bitset_keep: assert property (dmem_we_o |-> dmem_wdata_o[ir_q[BSEL_POS +: 3]]
        && ((dmem_wdata_o ^ data_q) & ~(8'h01 << ir_q[BSEL_POS +: 3])) == 8'h00)
        else $error("bit set disturbed other bits");
    a_read_phase: assert property (dmem_rd_o |-> ph_q == PH_Q2)
        else $error("read strobe outside second phase");
    a_write_phase: assert property (dmem_we_o |-> ph_q == PH_Q4)
        else $error("write strobe outside fourth phase");
    a_read_only_mem: assert property ((ph_q == PH_Q1 && !is_mem) |=> !dmem_rd_o)
        else $error("read strobe without memory operand");
    a_write_only_set: assert property ((ph_q == PH_Q3 && !is_bit_set) |=> !dmem_we_o)
        else $error("write strobe without bit set");
    a_addr_hold: assert property (ph_q != PH_Q1 |=> $stable(dmem_addr_o))
        else $error("data address moved inside a cycle");
    a_bank_addr: assert property ((ph_q == PH_Q1 && is_mem && amode)
        |=> dmem_addr_o == {$past(bank_select_register_i), $past(ffield)})
        else $error("banked address wrong");
    a_index_addr: assert property ((ph_q == PH_Q1 && is_mem && !amode && ext_en_i && ffield <= INDEX_MAX)
        |=> dmem_addr_o == $past(idx_base_i) + {4'h0, $past(ffield)})
        else $error("indexed address wrong");
    a_shared_addr: assert property ((ph_q == PH_Q1 && is_mem && !amode
        && !(ext_en_i && ffield <= INDEX_MAX))
        |=> dmem_addr_o == {(($past(ffield) < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK), $past(ffield)})
        else $error("shared bank address wrong");

    // Skip
    a_test_read: assert property ((ph_q == PH_Q1 && (is_test_clr || is_test_set)) |=> dmem_rd_o)
        else $error("bit test did not read its register");
    a_skip_clear: assert property ((ph_q == PH_Q4 && is_test_clr && !data_q[ir_q[BSEL_POS +: 3]])
        |=> !ir_valid_q)
        else $error("clear test did not skip");
    a_skip_set: assert property ((ph_q == PH_Q4 && is_test_set && data_q[ir_q[BSEL_POS +: 3]])
        |=> !ir_valid_q)
        else $error("set test did not skip");
    a_clear_keep: assert property ((ph_q == PH_Q4 && is_test_clr && data_q[ir_q[BSEL_POS +: 3]])
        |=> ir_valid_q)
        else $error("clear test skipped on a set bit");
    a_set_keep: assert property ((ph_q == PH_Q4 && is_test_set && !data_q[ir_q[BSEL_POS +: 3]])
        |=> ir_valid_q)
        else $error("set test skipped on a clear bit");
    a_keep_next: assert property ((ph_q == PH_Q4 && !is_branch && !skip_take) |=> ir_valid_q)
        else $error("next word dropped without a skip");
    a_skip_no_write: assert property ((ph_q == PH_Q4 && skip_take) |=> !dmem_we_o [*4])
        else $error("skipped word still wrote memory");

    // Main scenarios
    c_branch: cover property (ph_q == PH_Q4 && is_branch);
    c_bitset: cover property (dmem_we_o);
    c_skip: cover property (ph_q == PH_Q4 && skip_take);
    c_no_skip: cover property (ph_q == PH_Q4 && (is_test_clr || is_test_set) && !skip_take);
    c_indexed: cover property (ph_q == PH_Q1 && is_mem && !amode && ext_en_i && ffield <= INDEX_MAX);
endmodule : rbs_exec

/* File: sim/rbs_tb.sv */
// Self-checking bench for the branch / bit-set execute sequencer.
// Assumes program and data memories answer in the same clock, modelled here by arrays.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import rbs_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] bank_select_register_i = 4'h5;
    logic ext_en_i = 1'b0;
    logic [DADDR_W-1:0] idx_base_i = 12'hFF0;
    logic [15:0] prog [0:4095];
    logic [7:0] dm [0:4095];
    logic [PC_W-1:0] fetch_addr_o;
    logic [DADDR_W-1:0] dmem_addr_o;
    logic dmem_rd_o;
    logic dmem_we_o;
    logic flags_we_o;
    logic [7:0] dmem_wdata_o;
    int miscompares = 0;
    int num_checks = 0;
    int nwr;
    int nfl;

    always #2 sys_clk_i = ~sys_clk_i;

    rbs_exec uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_i(prog[fetch_addr_o[12:1]]),
        .dmem_rdata_i(dm[dmem_addr_o]), .bank_select_register_i(bank_select_register_i),
        .ext_en_i(ext_en_i), .idx_base_i(idx_base_i),
        .fetch_addr_o(fetch_addr_o), .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o),
        .dmem_we_o(dmem_we_o), .dmem_wdata_o(dmem_wdata_o), .flags_we_o(flags_we_o));

    // Counts write strobes and flag writes since the last reset
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nwr <= 0;
            nfl <= 0;
        end else begin
            nwr <= nwr + int'(dmem_we_o);
            nfl <= nfl + int'(flags_we_o);
        end
    end

    task summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task run(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : run

    task restart(input logic ext);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        ext_en_i <= ext;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask : restart

    task do_branch;
        for (int i = 0; i < 4096; i++) prog[i] = 16'h0000;
        prog[0] = 16'hD3FF;
        prog[12'h400] = 16'hD400;
        prog[1] = 16'hD800;
        restart(1'b0);
        run(8);
        chk("pc_fwd", fetch_addr_o, 32'h800);
        run(4);
        chk("pc_nop", fetch_addr_o, 32'h802);
        run(4);
        chk("pc_back", fetch_addr_o, 32'h2);
        run(8);
        chk("pc_other", fetch_addr_o, 32'h6);
        chk("flags_br", nfl, 32'h0);
    endtask : do_branch

    task do_bset(input logic a, input logic ext, input logic [7:0] f, input logic [2:0] b, input logic [11:0] ea);
        for (int i = 0; i < 4096; i++) prog[i] = 16'h0000;
        prog[0] = {OPC_BIT_SET, b, a, f};
        dm[ea] = 8'h0A;
        restart(ext);
        run(5);
        chk("rd_q2", dmem_rd_o, 32'h1);
        chk("addr", dmem_addr_o, ea);
        run(1);
        chk("rd_q3", dmem_rd_o, 32'h0);
        run(1);
        chk("we_q4", dmem_we_o, 32'h1);
        chk("wdata", dmem_wdata_o, 8'h0A | (8'h01 << b));
        run(1);
        chk("we_end", dmem_we_o, 32'h0);
        chk("flags_bs", nfl, 32'h0);
    endtask : do_bset

    task do_skip(input logic [3:0] opc, input logic [2:0] b, input int exp_wr);
        for (int i = 0; i < 4096; i++) prog[i] = 16'h0000;
        prog[0] = {opc, b, 1'b1, 8'h20};
        prog[1] = 16'h8010;
        dm[12'h520] = 8'h01;
        dm[12'h010] = 8'h00;
        restart(1'b0);
        run(16);
        chk("skip_wr", nwr, exp_wr);
        chk("skip_pc", fetch_addr_o, 32'h8);
    endtask : do_skip

    initial begin
        do_branch();
        do_bset(1'b1, 1'b0, 8'h80, 3'h7, 12'h580);
        do_bset(1'b0, 1'b0, 8'h5F, 3'h3, 12'h05F);
        do_bset(1'b0, 1'b0, 8'h60, 3'h0, 12'hF60);
        do_bset(1'b0, 1'b1, 8'h5F, 3'h7, 12'h04F);
        do_bset(1'b0, 1'b1, 8'h60, 3'h3, 12'hF60);
        do_skip(OPC_TEST_CLR, 3'h0, 1);
        do_skip(OPC_TEST_CLR, 3'h1, 0);
        do_skip(OPC_TEST_SET, 3'h0, 0);
        do_skip(OPC_TEST_SET, 3'h1, 1);
        summarize();
    end

    // Cuts a hang short
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule : testbench
